/* File: bench/vss_partner.sv */
// far-side model: thread dispatcher and output consumer readiness
`timescale 1ns/1ps
module vss_partner (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic stall,
  input wire logic slow,
  output logic disp_ready,
  output logic out_ready
);
  logic phase;
  // phase flop lets slow mode accept only on alternate cycles
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      phase <= 1'b0;
    end else begin
      phase <= ~phase;
    end
  end
  // the two sinks alternate in slow mode, so both see back pressure
  assign disp_ready = !reset && !stall && (!slow || phase);
  assign out_ready = !reset && !stall && (!slow || !phase);
endmodule : vss_partner

/* File: bench/vss_stage_tb.sv */
// self-checking bench of the vertex shading stage
`timescale 1ns/1ps
module vss_stage_tb;
  import vss_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic fn_enable = 1'b1;
  logic cache_enable = 1'b0;
  logic stats_enable = 1'b1;
  logic flush_req = 1'b0;
  logic draw_boundary = 1'b0;
  logic alloc_load = 1'b0;
  logic [DW-1:0] alloc_dword = 32'h00000000;
  logic in_valid = 1'b0;
  logic stall = 1'b0;
  logic slow = 1'b0;
  vss_cfg_t cfg;
  vss_vtx_t in_vtx;
  logic in_ready, disp_valid, disp_ready, out_valid, out_ready;
  logic cache_invalidate, alloc_fault;
  vss_disp_t disp;
  vss_ref_t out_ref;
  logic [15:0] shader_run_counter;
  logic [15:0] c0;
  logic [3:0] const_buf_offset;
  logic [4:0] const_buf_size;
  int n_fail = 0;
  int num_checks = 0;
  int n_thr = 0;
  vss_disp_t dq[$];
  vss_ref_t rq[$];
  vss_vtx_t vs[5];

  always #12.5 clk_sys = ~clk_sys;

  vss_stage #(.CNT_W(16)) i_vss_stage (.clk_sys(clk_sys), .reset(reset),
    .fn_enable(fn_enable), .cache_enable(cache_enable),
    .stats_enable(stats_enable), .flush_req(flush_req),
    .draw_boundary(draw_boundary), .cfg(cfg), .alloc_load(alloc_load),
    .alloc_dword(alloc_dword), .in_valid(in_valid), .in_ready(in_ready),
    .in_vtx(in_vtx), .disp_valid(disp_valid), .disp_ready(disp_ready),
    .disp(disp), .out_valid(out_valid), .out_ready(out_ready),
    .out_ref(out_ref), .shader_run_counter(shader_run_counter),
    .cache_invalidate(cache_invalidate),
    .const_buf_offset(const_buf_offset), .const_buf_size(const_buf_size),
    .alloc_fault(alloc_fault));

  vss_partner i_vss_partner (.clk_sys(clk_sys), .reset(reset),
    .stall(stall), .slow(slow), .disp_ready(disp_ready),
    .out_ready(out_ready));

  // collect every accepted thread request and output reference
  always @(posedge clk_sys) begin
    if (disp_valid && disp_ready) dq.push_back(disp);
    if (out_valid && out_ready) rq.push_back(out_ref);
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim;
    if (n_fail == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim

  function automatic vss_vtx_t mk(input int s, input int d, input logic h,
                                  input logic f, input logic l);
    mk.src = s[HANDLE_W-1:0];
    mk.dst = d[HANDLE_W-1:0];
    mk.hit = h;
    mk.kind = s[KIND_W-1:0];
    mk.first = f;
    mk.last = l;
  endfunction : mk

  // called at a falling edge; returns at the falling edge after the take
  task automatic send(input vss_vtx_t v);
    int k;
    in_valid = 1'b1;
    in_vtx = v;
    k = 0;
    while (in_ready !== 1'b1 && k < 200) begin
      @(negedge clk_sys);
      k++;
    end
    chk(k < 200, 1'b1);
    @(negedge clk_sys);
  endtask : send

  // bounded wait, then two quiet cycles to catch any surplus output
  task automatic wait_q(input int nr, input int nd);
    int k;
    k = 0;
    while ((rq.size() < nr || dq.size() < nd) && k < 200) begin
      @(negedge clk_sys);
      k++;
    end
    repeat (2) @(negedge clk_sys);
    chk(rq.size(), nr);
    chk(dq.size(), nd);
  endtask : wait_q

  task automatic start;
    dq.delete();
    rq.delete();
    c0 = shader_run_counter;
  endtask : start

  task automatic chk_disp(input vss_disp_t d, input logic [11:0] s0,
    input logic [11:0] h0, input logic [11:0] s1, input logic [11:0] h1,
    input logic [1:0] m);
    logic [3:0] sc;
    // codes past the largest legal size are expected held at the largest
    sc = (cfg.scratch_code > SCRATCH_CODE_MAX) ? SCRATCH_CODE_MAX
                                               : cfg.scratch_code;
    chk(d.exec_mask, m);
    chk(d.hdr[HDR_H0], h0);
    chk(d.hdr[HDR_H1], h1);
    chk(d.hdr[HDR_ZERO], 32'h00000000);
    chk(d.hdr[HDR_SAMP], {cfg.sampler_ptr, 1'b0, sc});
    chk(d.hdr[HDR_BIND], {cfg.binding_ptr, 5'h00});
    chk(d.hdr[HDR_SCR],
        {cfg.scratch_ofs, 3'h0, n_thr[6:0]});
    chk(d.hdr[HDR_TID], {8'h00, n_thr[23:0]});
    chk(d.const_len, 18'h0000A);
    chk({d.vtx_rd_ofs, d.vtx_rd_len, d.lane_src},
        {cfg.vtx_rd_ofs, cfg.vtx_rd_len, s1, s0});
    n_thr++;
  endtask : chk_disp

  task automatic chk_refs(input int n);
    for (int i = 0; i < n; i++) begin
      chk(rq[i], {vs[i].dst, vs[i].kind,
                  vs[i].first, vs[i].last});
    end
  endtask : chk_refs

  // invalidate cause raised at the previous falling edge
  task automatic inv_expect;
    @(negedge clk_sys);
    draw_boundary = 1'b0;
    chk(cache_invalidate, 1'b1);
    @(negedge clk_sys);
    chk(cache_invalidate, 1'b0);
  endtask : inv_expect

  task automatic alloc_chk(input logic [31:0] w, input logic [3:0] o,
                           input logic [4:0] s, input logic f);
    alloc_dword = w;
    alloc_load = 1'b1;
    @(negedge clk_sys);
    alloc_load = 1'b0;
    @(negedge clk_sys);
    chk(const_buf_offset, o);
    chk({const_buf_size, alloc_fault}, {s, f});
  endtask : alloc_chk

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_pair;
    cache_enable = 1'b0;
    start();
    vs[0] = mk(1, 11, 1'b0, 1'b1, 1'b0);
    vs[1] = mk(2, 12, 1'b0, 1'b0, 1'b1);
    send(vs[0]);
    send(vs[1]);
    in_valid = 1'b0;
    wait_q(2, 1);
    chk_disp(dq[0], 12'h001, 12'h00B, 12'h002, 12'h00C,
             MASK_PAIR);
    chk_refs(2);
    chk(shader_run_counter - c0, 16'h0002);
  endtask : t_pair

  task automatic t_flush;
    start();
    vs[0] = mk(3, 13, 1'b0, 1'b1, 1'b1);
    send(vs[0]);
    in_valid = 1'b0;
    flush_req = 1'b1;
    wait_q(1, 1);
    flush_req = 1'b0;
    chk_disp(dq[0], 12'h003, 12'h00D, 12'h003, 12'h00D,
             MASK_LOW);
    chk_refs(1);
    chk(shader_run_counter - c0, 16'h0001);
  endtask : t_flush

  // a hit behind a lone miss forces that miss out alone
  task automatic t_cache;
    cache_enable = 1'b1;
    // an out-of-range scratch code must come out saturated
    cfg.scratch_code = 4'hC;
    start();
    vs[0] = mk(5, 21, 1'b0, 1'b1, 1'b0);
    vs[1] = mk(6, 40, 1'b1, 1'b0, 1'b0);
    vs[2] = mk(7, 22, 1'b0, 1'b0, 1'b0);
    vs[3] = mk(8, 23, 1'b0, 1'b0, 1'b1);
    for (int i = 0; i < 4; i++) send(vs[i]);
    in_valid = 1'b0;
    wait_q(4, 2);
    chk_disp(dq[0], 12'h005, 12'h015, 12'h005, 12'h015,
             MASK_LOW);
    chk_disp(dq[1], 12'h007, 12'h016, 12'h008, 12'h017,
             MASK_PAIR);
    chk_refs(4);
    chk(shader_run_counter - c0, 16'h0003);
    cfg.scratch_code = 4'h5;
  endtask : t_cache

  task automatic t_fnoff;
    start();
    fn_enable = 1'b0;
    inv_expect();
    for (int i = 0; i < 3; i++) vs[i] = mk(9 + i, 30 + i, 1'b0, 1'b0, 1'b0);
    for (int i = 0; i < 3; i++) send(vs[i]);
    in_valid = 1'b0;
    wait_q(3, 0);
    chk_refs(3);
    chk(shader_run_counter - c0, 16'h0003);
    fn_enable = 1'b1;
    inv_expect();
    draw_boundary = 1'b1;
    inv_expect();
    cache_enable = 1'b0;
    inv_expect();
  endtask : t_fnoff

  // hits pile up against a stalled consumer, then drain slowly
  task automatic t_stall;
    cache_enable = 1'b1;
    start();
    stall = 1'b1;
    for (int i = 0; i < 5; i++) vs[i] = mk(12 + i, 50 + i, 1'b1, 1'b0, 1'b1);
    fork
      begin
        for (int i = 0; i < 5; i++) send(vs[i]);
        in_valid = 1'b0;
      end
      begin
        repeat (20) @(negedge clk_sys);
        chk(in_ready, 1'b0);
        chk(rq.size(), 0);
        stall = 1'b0;
        slow = 1'b1;
      end
    join
    wait_q(5, 0);
    chk_refs(5);
    chk(shader_run_counter - c0, 16'h0000);
    slow = 1'b0;
  endtask : t_stall

  task automatic t_alloc;
    alloc_chk(32'h000A0007, 4'hA, 5'h07, 1'b0);
    alloc_chk(32'h00000000, 4'h0, 5'h00, 1'b1);
    cfg.const_rlen = '0;
    alloc_chk(32'h000F0000, 4'hF, 5'h00, 1'b0);
    cfg.const_rlen = {16'h0004, 16'h0003, 16'h0002, 16'h0001};
  endtask : t_alloc

  // main sequence: reset, then every scenario in turn
  initial begin
    cfg.sampler_ptr = 27'h0000123;
    cfg.binding_ptr = 27'h0000456;
    cfg.scratch_ofs = 22'h00ABC;
    cfg.scratch_code = 4'h5;
    cfg.vtx_rd_ofs = 6'h02;
    cfg.vtx_rd_len = 6'h03;
    cfg.const_rlen = {16'h0004, 16'h0003, 16'h0002, 16'h0001};
    in_vtx = '0;
    repeat (8) @(negedge clk_sys);
    chk({disp_valid, out_valid, alloc_fault}, 3'h0);
    chk({shader_run_counter, const_buf_offset,
         const_buf_size}, 25'h0);
    reset = 1'b0;
    repeat (3) @(negedge clk_sys);
    t_pair();
    t_flush();
    t_cache();
    t_fnoff();
    t_stall();
    t_alloc();
    end_sim();
  end

  // watchdog at 8000 cycles, far beyond the hundred or so cycles the scenarios need
  initial begin
    #200000;
    n_fail++;
    end_sim();
  end
endmodule : vss_stage_tb

/* File: logic/vss_buf2.sv */
// two-entry buffer whose head entry is a flip-flop
`timescale 1ns/1ps
module vss_buf2 #(
  parameter int W = 8
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic v1;
  logic [W-1:0] d1;
  logic push;
  logic pop;

  // room while the back slot is empty, so a stall never drops a word
  assign in_ready = !v1;
  assign push = in_valid && !v1;
  assign pop = out_valid && out_ready;

  // head shifts forward on pop, new word goes to first free slot
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      out_valid <= 1'b0;
      v1 <= 1'b0;
      out_data <= '0;
      d1 <= '0;
    end else if (pop && v1) begin
      out_data <= d1;
      v1 <= 1'b0;
    end else if (pop) begin
      out_valid <= push;
      out_data <= in_data;
    end else if (push && !out_valid) begin
      out_valid <= 1'b1;
      out_data <= in_data;
    end else if (push) begin
      v1 <= 1'b1;
      d1 <= in_data;
    end
  end
endmodule : vss_buf2

/* File: logic/vss_hdr.sv */
// assembles the eight payload header dwords of one thread request
`timescale 1ns/1ps
module vss_hdr (
  input wire vss_pkg::vss_cfg_t cfg,
  input wire logic [vss_pkg::HANDLE_W-1:0] handle0,
  input wire logic [vss_pkg::HANDLE_W-1:0] handle1,
  input wire logic [vss_pkg::TID_W-1:0] thread_id,
  input wire logic [vss_pkg::TAG_W-1:0] thread_tag,
  output logic [vss_pkg::HDR_DWORDS-1:0][vss_pkg::DW-1:0] hdr
);
  import vss_pkg::*;
  logic [3:0] scr_code;
  // codes past the largest legal size are held at the largest one
  assign scr_code = (cfg.scratch_code > SCRATCH_CODE_MAX) ?
                    SCRATCH_CODE_MAX : cfg.scratch_code;

  // result handles sit in the low bits, the rest of each dword is zero
  assign hdr[HDR_H0] = {{(DW-HANDLE_W){1'b0}}, handle0};
  assign hdr[HDR_H1] = {{(DW-HANDLE_W){1'b0}}, handle1};
  assign hdr[HDR_ZERO] = '0;
  assign hdr[HDR_SAMP] = {cfg.sampler_ptr, 1'b0, scr_code};
  assign hdr[HDR_BIND] = {cfg.binding_ptr, 5'h00};
  // scratch offset above, thread tag in the low seven bits
  assign hdr[HDR_SCR] = {cfg.scratch_ofs, 3'h0,
                         thread_tag};
  assign hdr[HDR_TID] = {8'h00, thread_id};
  assign hdr[HDR_RSVD] = '0;
endmodule : vss_hdr

/* File: logic/vss_stage.sv */
// vertex shading stage: pairs misses into threads, keeps output in order
`timescale 1ns/1ps
module vss_stage #(
  parameter int CNT_W = 64
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic fn_enable,
  input wire logic cache_enable,
  input wire logic stats_enable,
  input wire logic flush_req,
  input wire logic draw_boundary,
  input wire vss_pkg::vss_cfg_t cfg,
  input wire logic alloc_load,
  input wire logic [vss_pkg::DW-1:0] alloc_dword,
  input wire logic in_valid,
  output logic in_ready,
  input wire vss_pkg::vss_vtx_t in_vtx,
  output logic disp_valid,
  input wire logic disp_ready,
  output vss_pkg::vss_disp_t disp,
  output logic out_valid,
  input wire logic out_ready,
  output vss_pkg::vss_ref_t out_ref,
  output logic [CNT_W-1:0] shader_run_counter,
  output logic cache_invalidate,
  output logic [3:0] const_buf_offset,
  output logic [4:0] const_buf_size,
  output logic alloc_fault
);
  import vss_pkg::*;

  // ****************************************************************
  // state and decode
  // ****************************************************************
  vss_state_t state;
  vss_state_t next_state;
  vss_vtx_t held;
  vss_ref_t second;
  vss_ref_t in_ref;
  vss_ref_t held_ref;
  vss_ref_t push_ref;
  vss_disp_t push_disp;
  logic [TID_W-1:0] thread_id;
  logic [TAG_W-1:0] thread_tag;
  logic prev_fn;
  logic prev_cache;
  logic disp_room;
  logic out_room;
  logic room;
  logic st_idle;
  logic st_held;
  logic st_second;
  logic in_hit;
  logic flush_now;
  logic take_in;
  logic pass_thru;
  logic hold_new;
  logic flush_one;
  logic pair_go;
  logic hit_one;
  logic single;
  logic disp_push;
  logic out_push;
  logic [1:0] inc;
  logic [CLEN_W-1:0] const_len;
  logic [HANDLE_W-1:0] handle1;

  assign st_idle = (state == ST_IDLE);
  assign st_held = (state == ST_HELD);
  assign st_second = (state == ST_SECOND);
  assign room = disp_room && out_room;
  // a hit flag only counts while the cache is in use
  assign in_hit = in_vtx.hit && cache_enable;
  // a state change or the function dropping closes the open pair
  assign flush_now = flush_req || !fn_enable;
  assign in_ready = room && !st_second && !(st_held && flush_now);
  assign take_in = in_valid && in_ready;
  assign pass_thru = st_idle && take_in &&
                     (!fn_enable || in_hit);
  assign hold_new = st_idle && take_in && fn_enable && !in_hit;
  assign flush_one = st_held && room && flush_now;
  assign pair_go = st_held && take_in && !in_hit;
  // a hit behind a lone miss cannot leave first, so the miss goes alone
  assign hit_one = st_held && take_in && in_hit;
  assign single = flush_one || hit_one;
  assign disp_push = flush_one || pair_go || hit_one;
  assign out_push = pass_thru || disp_push || (st_second && out_room);

  // ****************************************************************
  // output reference selection
  // ****************************************************************
  // tags are copied untouched, hits keep their cached entry handle
  assign in_ref = '{dst: in_vtx.dst, kind: in_vtx.kind,
                    first: in_vtx.first, last: in_vtx.last};
  assign held_ref = '{dst: held.dst, kind: held.kind,
                      first: held.first, last: held.last};
  // the older vertex always leaves before the newer one
  assign push_ref = st_second ? second :
                    (disp_push ? held_ref : in_ref);

  // ****************************************************************
  // thread request assembly
  // ****************************************************************
  // a lone vertex repeats its own handle so the kernel can spot it
  assign handle1 = single ? held.dst : in_vtx.dst;
  assign const_len = {2'b00, cfg.const_rlen[0]} + {2'b00, cfg.const_rlen[1]}
                   + {2'b00, cfg.const_rlen[2]}
                   + {2'b00, cfg.const_rlen[3]};
  assign push_disp.exec_mask = single ? MASK_LOW : MASK_PAIR;
  assign push_disp.const_len = const_len;
  assign push_disp.vtx_rd_ofs = cfg.vtx_rd_ofs;
  assign push_disp.vtx_rd_len = cfg.vtx_rd_len;
  // lane 0 fills dwords 0-3, lane 1 dwords 4-7 of each payload register
  assign push_disp.lane_src[0] = held.src;
  assign push_disp.lane_src[1] = single ? held.src : in_vtx.src;

  vss_hdr u_hdr (
    .cfg(cfg),
    .handle0(held.dst),
    .handle1(handle1),
    .thread_id(thread_id),
    .thread_tag(thread_tag),
    .hdr(push_disp.hdr)
  );

  // ****************************************************************
  // output buffers
  // ****************************************************************
  vss_buf2 #(.W($bits(vss_disp_t))) u_disp_buf (
    .clk_sys(clk_sys),
    .reset(reset),
    .in_valid(disp_push),
    .in_ready(disp_room),
    .in_data(push_disp),
    .out_valid(disp_valid),
    .out_ready(disp_ready),
    .out_data(disp)
  );

  vss_buf2 #(.W($bits(vss_ref_t))) u_out_buf (
    .clk_sys(clk_sys),
    .reset(reset),
    .in_valid(out_push),
    .in_ready(out_room),
    .in_data(push_ref),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_ref)
  );

  // ****************************************************************
  // sequencing
  // ****************************************************************
  // idle holds a miss, held emits a thread, second emits the newer ref
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: next_state = hold_new ? ST_HELD : ST_IDLE;
      ST_HELD: begin
        if (flush_one) begin
          next_state = ST_IDLE;
        end else if (pair_go || hit_one) begin
          next_state = ST_SECOND;
        end
      end
      ST_SECOND: next_state = out_room ? ST_IDLE : ST_SECOND;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // storage for the unpaired miss and the reference waiting behind it
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      held <= '0;
      second <= '0;
    end else begin
      if (hold_new) begin
        held <= in_vtx;
      end
      if (pair_go || hit_one) begin
        second <= in_ref;
      end
    end
  end

  // identifiers wrap; the tag range is small enough to alias in flight
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      thread_id <= '0;
      thread_tag <= '0;
    end else if (disp_push) begin
      thread_id <= thread_id + 1'b1;
      thread_tag <= thread_tag + 1'b1;
    end
  end

  // ****************************************************************
  // statistics
  // ****************************************************************
  // hits served from the cache are never counted while shading is on
  assign inc = !stats_enable ? 2'h0 :
               (pass_thru && !fn_enable) ? 2'h1 :
               pair_go ? 2'h2 : (single ? 2'h1 : 2'h0);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      shader_run_counter <= '0;
    end else begin
      shader_run_counter <= shader_run_counter + CNT_W'(inc);
    end
  end

  // ****************************************************************
  // cache invalidation and constant space allocation
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      prev_fn <= 1'b0;
      prev_cache <= 1'b0;
      cache_invalidate <= 1'b0;
    end else begin
      prev_fn <= fn_enable;
      prev_cache <= cache_enable;
      cache_invalidate <= (prev_cache && !cache_enable) ||
                          (prev_fn != fn_enable) || draw_boundary;
    end
  end

  // zero size is only sane while no constant read is enabled
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      const_buf_offset <= ALLOC_OFS_RST;
      const_buf_size <= ALLOC_SIZE_RST;
      alloc_fault <= 1'b0;
    end else begin
      if (alloc_load) begin
        const_buf_offset <= alloc_dword[ALLOC_OFS_HI:ALLOC_OFS_LO];
        const_buf_size <=
          alloc_dword[ALLOC_SIZE_HI:ALLOC_SIZE_LO];
      end
      alloc_fault <= (const_buf_size == 5'h00) &&
                     (const_len != '0);
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  pair_mask_a: assert property (
    pair_go |-> push_disp.exec_mask == MASK_PAIR)
    else $error("pair dispatch without both lanes");
  single_mask_a: assert property (
    flush_one |-> disp_push && push_disp.exec_mask == MASK_LOW)
    else $error("flush did not send a lone lane");
  hit_bypass_a: assert property (
    pass_thru && fn_enable |-> !disp_push && out_push && push_ref == in_ref)
    else $error("cache hit was shaded");
  order_keep_a: assert property (
    disp_push && !flush_one |=> st_second && second == $past(in_ref))
    else $error("newer reference not queued behind held one");
  lone_miss_a: assert property (
    hit_one |-> push_disp.exec_mask == MASK_LOW && push_ref == held_ref)
    else $error("blocking miss not sent alone");
  handle_pair_a: assert property (
    disp_push |-> (push_disp.hdr[HDR_H0] == push_disp.hdr[HDR_H1]) ==
    (single || held.dst == in_vtx.dst))
    else $error("result handles do not tell lane count");
  zero_dword_a: assert property (
    disp_push |-> push_disp.hdr[HDR_ZERO] == '0)
    else $error("header dword 2 not zero");
  count_pair_a: assert property (
    pair_go && stats_enable |=>
    shader_run_counter == $past(shader_run_counter) + CNT_W'(2))
    else $error("pair did not add two");
  count_pass_a: assert property (
    pass_thru && !fn_enable && stats_enable |=>
    shader_run_counter == $past(shader_run_counter) + CNT_W'(1))
    else $error("pass-through vertex not counted");
  inval_fall_a: assert property (
    $fell(cache_enable) |-> ##[1:2] cache_invalidate)
    else $error("cache disable did not invalidate");

  pair_seen_c: cover property (pair_go ##1 st_second ##[1:4] st_idle);
  hit_lone_c: cover property (hit_one);
  flush_c: cover property (flush_one);
  pass_c: cover property (pass_thru && !fn_enable);
endmodule : vss_stage

/* File: shared/vss_pkg.sv */
// shared constants and carrier types of the vertex shading stage dispatcher
package vss_pkg;
  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int HANDLE_W = 12;
  localparam int KIND_W = 5;
  localparam int DW = 32;
  localparam int HDR_DWORDS = 8;
  localparam int TID_W = 24;
  localparam int TAG_W = 7;
  localparam int RLEN_W = 16;
  localparam int CLEN_W = 18;
  localparam int PTR_W = 27;
  localparam int SCR_OFS_W = 22;
  localparam int VRD_W = 6;

  // ****************************************************************
  // constant space allocation dword fields and reset values
  // ****************************************************************
  localparam int ALLOC_OFS_LO = 16;
  localparam int ALLOC_OFS_HI = 19;
  localparam int ALLOC_SIZE_LO = 0;
  localparam int ALLOC_SIZE_HI = 4;
  localparam logic [3:0] ALLOC_OFS_RST = 4'h0;
  localparam logic [4:0] ALLOC_SIZE_RST = 5'h00;

  // ****************************************************************
  // payload header field positions
  // ****************************************************************
  localparam int HDR_H0 = 0;
  localparam int HDR_H1 = 1;
  localparam int HDR_ZERO = 2;
  localparam int HDR_SAMP = 3;
  localparam int HDR_BIND = 4;
  localparam int HDR_SCR = 5;
  localparam int HDR_TID = 6;
  localparam int HDR_RSVD = 7;
  localparam int PTR_LO = 5;
  localparam int SCR_OFS_LO = 10;
  localparam logic [3:0] SCRATCH_CODE_MAX = 4'hB;

  // ****************************************************************
  // execution masks and states
  // ****************************************************************
  localparam logic [1:0] MASK_PAIR = 2'h3;
  localparam logic [1:0] MASK_LOW = 2'h1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_HELD = 3'b010,
    ST_SECOND = 3'b100
  } vss_state_t;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic [HANDLE_W-1:0] src;
    logic [HANDLE_W-1:0] dst;
    logic hit;
    logic [KIND_W-1:0] kind;
    logic first;
    logic last;
  } vss_vtx_t;

  typedef struct packed {
    logic [HANDLE_W-1:0] dst;
    logic [KIND_W-1:0] kind;
    logic first;
    logic last;
  } vss_ref_t;

  typedef struct packed {
    logic [PTR_W-1:0] sampler_ptr;
    logic [PTR_W-1:0] binding_ptr;
    logic [SCR_OFS_W-1:0] scratch_ofs;
    logic [3:0] scratch_code;
    logic [VRD_W-1:0] vtx_rd_ofs;
    logic [VRD_W-1:0] vtx_rd_len;
    logic [3:0][RLEN_W-1:0] const_rlen;
  } vss_cfg_t;

  typedef struct packed {
    logic [HDR_DWORDS-1:0][DW-1:0] hdr;
    logic [1:0] exec_mask;
    logic [CLEN_W-1:0] const_len;
    logic [VRD_W-1:0] vtx_rd_ofs;
    logic [VRD_W-1:0] vtx_rd_len;
    logic [1:0][HANDLE_W-1:0] lane_src;
  } vss_disp_t;
endpackage : vss_pkg
